// [ccbs_sequencer.sv]
// Cycle-level sequencer for loads, stores, decrement, branches, calls and returns.
// Operation
// - Loading the accumulator copies bit 7 of the byte into msb_copy_flag.
// - branch_if_positive branches when msb_copy_flag is clear, else falls through.
// - branch_on_cleared_bit branches when the chosen direct byte bit is zero; 0f tests 7.
// - Bit-test loop is one cycle and one byte shorter than load plus branch.
// - Immediate load takes two cycles: opcode fetch, then operand into accumulator.
// - Absolute call: fetch opcode, read target high, read target low, form address.
// - Call pushes return low then high byte, decrementing stack_pointer after each.
// - After the pushes program_counter takes the target; next cycle fetches there.
// - decrement_accumulator takes three cycles, subtracts one and updates result_empty_flag.
// - branch_if_nonzero adds signed offset to program_counter when result_empty_flag clear.
// - branch_if_nonzero falls through to the next instruction when result_empty_flag set.
// - Return takes six cycles, pulling high then low byte with pre-increments.
// - Direct store takes four cycles, writing accumulator to page zero last.
// - Return resumes after whichever call, absolute or relative, entered the subroutine.
// - A byte loaded into the accumulator sets result_empty_flag exactly when zero.
// - Flags an instruction does not define keep their previous values.
// - Bit-test branches use three bytes: opcode, direct address, signed offset.
`timescale 1ns/10ps
module ccbs_sequencer #(
    parameter logic [15:0] RESET_PC = 16'h0100
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] mem_rdata_in,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic instr_done_out,
    output logic [15:0] program_counter_out,
    output logic [7:0] stack_pointer_out,
    output logic [7:0] acc_out,
    output logic msb_copy_flag_out,
    output logic result_empty_flag_out
);

    if (ccbs_pkg::ADDR_W != 16 || ccbs_pkg::DATA_W != 8) begin : g_bus_width_check
        $error("ccbs_sequencer serves only a 16-bit address and an 8-bit data bus");
    end

    ccbs_pkg::ccbs_phase_e phase_reg;
    logic [2:0] step_reg;
    logic [15:0] pc_reg;
    logic [7:0] opcode_reg, sp_reg, acc_reg, direct_reg;
    logic [7:0] target_hi_reg, target_lo_reg, operand_reg;
    // Control terms decoded for the current cycle.
    logic last_step, pc_inc, pc_load, sp_dec, sp_inc, acc_load, flag_load, rd_c, wr_c;
    logic direct_load, target_hi_load, target_lo_load, operand_load;
    logic [15:0] pc_load_val, addr_c;
    logic [7:0] acc_load_val, wdata_c;
    logic is_bitbr, bit_sel_val, msb_flag, zero_flag;
    logic [15:0] rel_target, ret_addr;
    assign is_bitbr = (opcode_reg[7:4] == ccbs_pkg::OPC_BITBR_NIB);
    assign bit_sel_val =
        operand_reg[opcode_reg[ccbs_pkg::BITBR_SEL_LSB +: ccbs_pkg::BITBR_SEL_W]];
    // Relative targets use the offset held in operand_reg, taken after pc passed the branch.
    assign rel_target = pc_reg + {{8{operand_reg[ccbs_pkg::MSB_POS]}}, operand_reg};
    assign ret_addr = pc_reg;
    always_comb begin
        last_step = 1'b0;
        pc_inc = 1'b0;
        pc_load = 1'b0;
        pc_load_val = pc_reg;
        sp_dec = 1'b0;
        sp_inc = 1'b0;
        acc_load = 1'b0;
        acc_load_val = acc_reg;
        flag_load = 1'b0;
        direct_load = 1'b0;
        target_hi_load = 1'b0;
        target_lo_load = 1'b0;
        operand_load = 1'b0;
        addr_c = ccbs_pkg::ADDR_IDLE;
        rd_c = 1'b0;
        wr_c = 1'b0;
        wdata_c = ccbs_pkg::BYTE_ZERO;
        if (phase_reg == ccbs_pkg::CCBS_FETCH) begin
            addr_c = pc_reg;
            rd_c = 1'b1;
            pc_inc = 1'b1;
        end else if (is_bitbr) begin
            unique case (step_reg)
                ccbs_pkg::STEP_1: begin
                    addr_c = pc_reg;
                    rd_c = 1'b1;
                    direct_load = 1'b1;
                    pc_inc = 1'b1;
                end
                ccbs_pkg::STEP_2: begin
                    addr_c = {ccbs_pkg::DIRECT_PAGE_HI, direct_reg};
                    rd_c = 1'b1;
                    operand_load = 1'b1;
                end
                ccbs_pkg::STEP_3: begin
                    addr_c = pc_reg;
                    rd_c = 1'b1;
                    target_lo_load = 1'b1;
                    pc_inc = 1'b1;
                end
                default: begin
                    last_step = 1'b1;
                    // Clear test when opcode bit 0 is one, set test otherwise.
                    if (bit_sel_val != opcode_reg[ccbs_pkg::BITBR_CLR_POS]) begin
                        pc_load = 1'b1;
                        pc_load_val = pc_reg + {{8{target_lo_reg[ccbs_pkg::MSB_POS]}},
                                                target_lo_reg};
                    end
                end
            endcase
        end else begin
            unique case (opcode_reg)
                ccbs_pkg::OPC_LOAD_IMM: begin
                    addr_c = pc_reg;
                    rd_c = 1'b1;
                    acc_load = 1'b1;
                    acc_load_val = mem_rdata_in;
                    flag_load = 1'b1;
                    pc_inc = 1'b1;
                    last_step = 1'b1;
                end
                ccbs_pkg::OPC_LOAD_DIR: begin
                    rd_c = 1'b1;
                    if (step_reg == ccbs_pkg::STEP_1) begin
                        addr_c = pc_reg;
                        direct_load = 1'b1;
                        pc_inc = 1'b1;
                    end else begin
                        addr_c = {ccbs_pkg::DIRECT_PAGE_HI, direct_reg};
                        acc_load = 1'b1;
                        acc_load_val = mem_rdata_in;
                        flag_load = 1'b1;
                        last_step = 1'b1;
                    end
                end
                ccbs_pkg::OPC_STORE_DIR: begin
                    unique case (step_reg)
                        ccbs_pkg::STEP_1: begin
                            addr_c = pc_reg;
                            rd_c = 1'b1;
                            direct_load = 1'b1;
                        end
                        ccbs_pkg::STEP_2: begin
                            pc_inc = 1'b1;
                        end
                        default: begin
                            addr_c = {ccbs_pkg::DIRECT_PAGE_HI, direct_reg};
                            wr_c = 1'b1;
                            wdata_c = acc_reg;
                            last_step = 1'b1;
                        end
                    endcase
                end
                ccbs_pkg::OPC_DEC_ACC: begin
                    if (step_reg == ccbs_pkg::STEP_1) begin
                        acc_load = 1'b1;
                        acc_load_val = acc_reg - ccbs_pkg::BYTE_ONE;
                        flag_load = 1'b1;
                    end else begin
                        last_step = 1'b1;
                    end
                end
                ccbs_pkg::OPC_BR_NONZERO, ccbs_pkg::OPC_BR_POSITIVE: begin
                    if (step_reg == ccbs_pkg::STEP_1) begin
                        addr_c = pc_reg;
                        rd_c = 1'b1;
                        operand_load = 1'b1;
                        pc_inc = 1'b1;
                    end else begin
                        last_step = 1'b1;
                        pc_load = (opcode_reg == ccbs_pkg::OPC_BR_NONZERO) ?
                                  !zero_flag : !msb_flag;
                        pc_load_val = rel_target;
                    end
                end
                ccbs_pkg::OPC_CALL_ABS, ccbs_pkg::OPC_CALL_REL: begin
                    unique case (step_reg)
                        ccbs_pkg::STEP_1: begin
                            addr_c = pc_reg;
                            rd_c = 1'b1;
                            pc_inc = 1'b1;
                            target_hi_load = (opcode_reg == ccbs_pkg::OPC_CALL_ABS);
                            operand_load = (opcode_reg == ccbs_pkg::OPC_CALL_REL);
                        end
                        ccbs_pkg::STEP_2: begin
                            if (opcode_reg == ccbs_pkg::OPC_CALL_ABS) begin
                                addr_c = pc_reg;
                                rd_c = 1'b1;
                                target_lo_load = 1'b1;
                                pc_inc = 1'b1;
                            end else begin
                                target_hi_load = 1'b1;
                                target_lo_load = 1'b1;
                            end
                        end
                        ccbs_pkg::STEP_3: begin
                            // Target formed internally; bus stays idle.
                        end
                        ccbs_pkg::STEP_4: begin
                            addr_c = {ccbs_pkg::STACK_PAGE_HI, sp_reg};
                            wr_c = 1'b1;
                            wdata_c = ret_addr[7:0];
                            sp_dec = 1'b1;
                        end
                        default: begin
                            addr_c = {ccbs_pkg::STACK_PAGE_HI, sp_reg};
                            wr_c = 1'b1;
                            wdata_c = ret_addr[15:8];
                            sp_dec = 1'b1;
                            pc_load = 1'b1;
                            pc_load_val = {target_hi_reg, target_lo_reg};
                            last_step = 1'b1;
                        end
                    endcase
                end
                ccbs_pkg::OPC_RETURN: begin
                    unique case (step_reg)
                        ccbs_pkg::STEP_1: begin
                        end
                        ccbs_pkg::STEP_2, ccbs_pkg::STEP_4: begin
                            sp_inc = 1'b1;
                        end
                        ccbs_pkg::STEP_3: begin
                            addr_c = {ccbs_pkg::STACK_PAGE_HI, sp_reg};
                            rd_c = 1'b1;
                            target_hi_load = 1'b1;
                        end
                        default: begin
                            addr_c = {ccbs_pkg::STACK_PAGE_HI, sp_reg};
                            rd_c = 1'b1;
                            pc_load = 1'b1;
                            pc_load_val = {target_hi_reg, mem_rdata_in};
                            last_step = 1'b1;
                        end
                    endcase
                end
                default: begin
                    // Opcodes outside this block retire as a two-cycle no-operation.
                    last_step = 1'b1;
                end
            endcase
        end
    end
    // Phase and step sequencing; fetch always follows the last execute step.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_reg <= ccbs_pkg::CCBS_FETCH;
            step_reg <= ccbs_pkg::STEP_1;
        end else if (phase_reg == ccbs_pkg::CCBS_FETCH) begin
            phase_reg <= ccbs_pkg::CCBS_EXEC;
            step_reg <= ccbs_pkg::STEP_1;
        end else if (last_step) begin
            phase_reg <= ccbs_pkg::CCBS_FETCH;
            step_reg <= ccbs_pkg::STEP_1;
        end else begin
            step_reg <= step_reg + ccbs_pkg::STEP_1;
        end
    end
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            opcode_reg <= ccbs_pkg::BYTE_ZERO;
        end else if (phase_reg == ccbs_pkg::CCBS_FETCH) begin
            opcode_reg <= mem_rdata_in;
        end
    end
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pc_reg <= RESET_PC;
        end else if (pc_load) begin
            pc_reg <= pc_load_val;
        end else if (pc_inc) begin
            pc_reg <= pc_reg + ccbs_pkg::ADDR_ONE;
        end
    end
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sp_reg <= ccbs_pkg::SP_RESET;
        end else if (sp_dec) begin
            sp_reg <= sp_reg - ccbs_pkg::BYTE_ONE;
        end else if (sp_inc) begin
            sp_reg <= sp_reg + ccbs_pkg::BYTE_ONE;
        end
    end
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            acc_reg <= ccbs_pkg::ACC_RESET;
        end else if (acc_load) begin
            acc_reg <= acc_load_val;
        end
    end
    // Operand latches; the relative call stores its computed target in the same pair.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            direct_reg <= ccbs_pkg::BYTE_ZERO;
            operand_reg <= ccbs_pkg::BYTE_ZERO;
            target_hi_reg <= ccbs_pkg::BYTE_ZERO;
            target_lo_reg <= ccbs_pkg::BYTE_ZERO;
        end else begin
            if (direct_load) begin
                direct_reg <= mem_rdata_in;
            end
            if (operand_load) begin
                operand_reg <= mem_rdata_in;
            end
            if (target_hi_load) begin
                target_hi_reg <= (opcode_reg == ccbs_pkg::OPC_CALL_REL) ?
                                 rel_target[15:8] : mem_rdata_in;
            end
            if (target_lo_load) begin
                target_lo_reg <= (opcode_reg == ccbs_pkg::OPC_CALL_REL) ?
                                 rel_target[7:0] : mem_rdata_in;
            end
        end
    end
    // Only loads and the decrement strobe the flags; all else leaves them untouched.
    ccbs_flag_unit #(.WIDTH(ccbs_pkg::DATA_W)) ccbs_flag_unit_i (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .load_in(flag_load),
        .value_in(acc_load_val),
        .msb_copy_flag_out(msb_flag),
        .result_empty_flag_out(zero_flag)
    );
    assign mem_addr_out = addr_c;
    assign mem_rd_out = rd_c;
    assign mem_wr_out = wr_c;
    assign mem_wdata_out = wdata_c;
    assign instr_done_out = (phase_reg == ccbs_pkg::CCBS_EXEC) && last_step;
    assign program_counter_out = pc_reg;
    assign stack_pointer_out = sp_reg;
    assign acc_out = acc_reg;
    assign msb_copy_flag_out = msb_flag;
    assign result_empty_flag_out = zero_flag;

endmodule : ccbs_sequencer

// [ccbs_pkg.sv]
// Shared constants for the call and branch sequencer: opcodes, reset values and field positions.
package ccbs_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;

    // Opcodes handled by the sequencer.
    localparam logic [7:0] OPC_LOAD_IMM = 8'hA6;
    localparam logic [7:0] OPC_LOAD_DIR = 8'hB6;
    localparam logic [7:0] OPC_STORE_DIR = 8'hB7;
    localparam logic [7:0] OPC_DEC_ACC = 8'h4A;
    localparam logic [7:0] OPC_BR_NONZERO = 8'h26;
    localparam logic [7:0] OPC_BR_POSITIVE = 8'h2A;
    localparam logic [7:0] OPC_CALL_REL = 8'hAD;
    localparam logic [7:0] OPC_CALL_ABS = 8'hCD;
    localparam logic [7:0] OPC_RETURN = 8'h81;

    // Bit test and branch family: high nibble zero, bit index in [3:1], clear test when [0] is one.
    localparam logic [3:0] OPC_BITBR_NIB = 4'h0;
    localparam int unsigned BITBR_SEL_LSB = 1;
    localparam int unsigned BITBR_SEL_W = 3;
    localparam int unsigned BITBR_CLR_POS = 0;

    localparam int unsigned MSB_POS = 7;

    // Direct page and stack page both sit in the lowest 256 bytes.
    localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;
    localparam logic [7:0] STACK_PAGE_HI = 8'h00;
    localparam logic [7:0] SP_RESET = 8'hFF;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] ADDR_ONE = 16'h0001;
    localparam logic [15:0] ADDR_IDLE = 16'h0000;

    // Execute-step indices; the opcode fetch has no index and runs with step_reg at STEP_1.
    localparam logic [2:0] STEP_1 = 3'h1;
    localparam logic [2:0] STEP_2 = 3'h2;
    localparam logic [2:0] STEP_3 = 3'h3;
    localparam logic [2:0] STEP_4 = 3'h4;
    localparam logic [2:0] STEP_5 = 3'h5;

    typedef enum logic [1:0] {
        CCBS_FETCH = 2'b01,
        CCBS_EXEC = 2'b10
    } ccbs_phase_e;

endpackage : ccbs_pkg

// [ccbs_flag_unit.sv]
// Sign and zero condition flags, updated from a byte whenever a load strobe is given.
`timescale 1ns/10ps
module ccbs_flag_unit #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] value_in,
    output logic msb_copy_flag_out,
    output logic result_empty_flag_out
);

    if (WIDTH < 2) begin : g_width_check
        $error("ccbs_flag_unit needs a width of at least two bits");
    end

    // Flags not strobed keep their value, so other instructions leave them alone.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            msb_copy_flag_out <= 1'b0;
        end else if (load_in) begin
            msb_copy_flag_out <= value_in[WIDTH-1];
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result_empty_flag_out <= 1'b0;
        end else if (load_in) begin
            result_empty_flag_out <= (value_in == '0);
        end
    end

endmodule : ccbs_flag_unit

// [ccbs_mem_model.sv]
// Zero-wait memory model with combinational read and clocked write.
`timescale 1ns/10ps
module ccbs_mem_model (
    input wire logic sys_clk_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic rd_in,
    input wire logic wr_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_reg = 8'h00;
    // An unread bus shows the inverse of the last byte, so stale data never passes as valid.
    assign rdata_out = rd_in ? mem[addr_in] : ~last_reg;
    always @(posedge sys_clk_in) begin
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
        if (rd_in) begin
            last_reg <= mem[addr_in];
        end
    end
endmodule : ccbs_mem_model

// [ccbs_sequencer_assertions.sv]
// Checker of the sequencer's bus timing, flags and program flow.
`timescale 1ns/10ps
module ccbs_sequencer_assertions (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [7:0] mem_rdata_in,
    input wire logic [15:0] mem_addr_out,
    input wire logic [7:0] mem_wdata_out,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic instr_done_out,
    input wire logic [15:0] program_counter_out,
    input wire logic [7:0] stack_pointer_out,
    input wire logic [7:0] acc_out,
    input wire logic msb_copy_flag_out,
    input wire logic result_empty_flag_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    logic fetch_reg;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fetch_reg <= 1'b1;
        end else begin
            fetch_reg <= instr_done_out;
        end
    end
    function automatic logic [15:0] sext(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction : sext
    sequence s_fetch(logic [7:0] op);
        fetch_reg && mem_rd_out && mem_rdata_in == op;
    endsequence
    sequence s_push_lo;
        mem_wr_out && mem_addr_out == {8'h00, stack_pointer_out}
            && mem_wdata_out == program_counter_out[7:0];
    endsequence
    sequence s_push_hi;
        mem_wr_out && instr_done_out && mem_addr_out == {8'h00, stack_pointer_out}
            && mem_wdata_out == program_counter_out[15:8]
            && stack_pointer_out == $past(stack_pointer_out) - 8'h01;
    endsequence
    a_load_imm_flags: assert property (s_fetch(8'hA6) |=> instr_done_out ##1
        (acc_out == $past(mem_rdata_in) && msb_copy_flag_out == acc_out[7]
        && result_empty_flag_out == (acc_out == 8'h00))) else $error("load result wrong");
    a_dec_acc_three: assert property (s_fetch(8'h4A) |=> !instr_done_out ##1
        instr_done_out ##1 (acc_out == $past(acc_out, 3) - 8'h01
        && result_empty_flag_out == (acc_out == 8'h00))) else $error("decrement wrong");
    a_store_acc_four: assert property (s_fetch(8'hB7) |-> ##1 !mem_wr_out ##2
        (mem_wr_out && instr_done_out && mem_addr_out == {8'h00, $past(mem_rdata_in, 2)}
        && mem_wdata_out == acc_out) ##1 (msb_copy_flag_out == $past(msb_copy_flag_out, 4)
        && result_empty_flag_out == $past(result_empty_flag_out, 4))) else $error("store wrong");
    a_call_push_order: assert property (s_fetch(8'hCD) |-> ##4 s_push_lo ##1 s_push_hi)
        else $error("call push wrong");
    a_call_target_fetch: assert property (s_fetch(8'hCD) |-> ##6 (mem_rd_out
        && program_counter_out == {$past(mem_rdata_in, 5), $past(mem_rdata_in, 4)}
        && mem_addr_out == program_counter_out)) else $error("call target wrong");
    a_return_six: assert property (s_fetch(8'h81) |-> ##5 instr_done_out ##1
        (program_counter_out == {$past(mem_rdata_in, 3), $past(mem_rdata_in, 1)}
        && stack_pointer_out == $past(stack_pointer_out, 6) + 8'h02))
        else $error("return wrong");
    a_branch_on_flag: assert property ((fetch_reg && mem_rd_out
        && (mem_rdata_in == 8'h26 || mem_rdata_in == 8'h2A)) |-> ##2 instr_done_out ##1
        (program_counter_out == $past(program_counter_out, 3) + 16'h0002
        + ((($past(mem_rdata_in, 3) == 8'h26) ? !result_empty_flag_out : !msb_copy_flag_out)
        ? sext($past(mem_rdata_in, 2)) : 16'h0000))) else $error("branch target wrong");
    a_bit_clear_branch: assert property (s_fetch(8'h0F) |-> ##4 instr_done_out ##1
        (program_counter_out == $past(program_counter_out, 5) + 16'h0003
        + ($past(mem_rdata_in[7], 3) ? 16'h0000 : sext($past(mem_rdata_in, 2)))))
        else $error("bit branch wrong");
    a_idle_bus_quiet: assert property (!mem_rd_out && !mem_wr_out |->
        mem_addr_out == 16'h0000 && mem_wdata_out == 8'h00) else $error("idle bus not quiet");
    a_done_then_fetch: assert property (instr_done_out |=> mem_rd_out
        && mem_addr_out == program_counter_out) else $error("fetch missing");
endmodule : ccbs_sequencer_assertions
bind ccbs_sequencer ccbs_sequencer_assertions ccbs_sequencer_assertions_i (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .mem_rdata_in(mem_rdata_in),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .instr_done_out(instr_done_out),
    .program_counter_out(program_counter_out), .stack_pointer_out(stack_pointer_out),
    .acc_out(acc_out), .msb_copy_flag_out(msb_copy_flag_out),
    .result_empty_flag_out(result_empty_flag_out));

// [cpu_call_branch_sequencer_tb.sv]
// Self-checking testbench running small programs through the sequencer.
`timescale 1ns/10ps
module cpu_call_branch_sequencer_tb;
    logic sys_clk_in, arst_n_in, mem_rd, mem_wr, done, msb, empty;
    logic [7:0] rdata, wdata, sp, acc;
    logic [15:0] addr, pc;
    int mismatches = 0;
    int n_compared = 0;
    int cyc;
    logic [7:0] prog [0:22] = '{8'hA6, 8'h02, 8'hCD, 8'h02, 8'h00, 8'hB7, 8'h02, 8'hA6, 8'h80,
        8'h2A, 8'h02, 8'h0F, 8'h01, 8'hFD, 8'hB6, 8'h01, 8'h2A, 8'hFC,
        8'hAD, 8'h0C, 8'h0E, 8'h01, 8'h02};
    ccbs_sequencer ccbs_sequencer_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .mem_rdata_in(rdata), .mem_addr_out(addr), .mem_wdata_out(wdata), .mem_rd_out(mem_rd),
        .mem_wr_out(mem_wr), .instr_done_out(done), .program_counter_out(pc),
        .stack_pointer_out(sp), .acc_out(acc), .msb_copy_flag_out(msb),
        .result_empty_flag_out(empty));
    ccbs_mem_model ccbs_mem_model_i (.sys_clk_in(sys_clk_in), .addr_in(addr),
        .wdata_in(wdata), .rd_in(mem_rd), .wr_in(mem_wr), .rdata_out(rdata));
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Runs one instruction to its done pulse and checks its length in cycles.
    task automatic step(input int exp_cyc);
        cyc = 0;
        do begin
            @(negedge sys_clk_in);
            cyc++;
        end while (done !== 1'b1 && cyc < 20);
        if (done !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        @(posedge sys_clk_in);
        #1;
        check(16'(cyc), 16'(exp_cyc));
    endtask : step
    task automatic test_call_return();
        step(2);
        check({7'h00, empty, acc}, 16'h0002);
        check({15'h0000, msb}, 16'h0000);
        step(6);
        check(pc, 16'h0200);
        check({8'h00, sp}, 16'h00FD);
        check({ccbs_mem_model_i.mem[16'h00FF], ccbs_mem_model_i.mem[16'h00FE]}, 16'h0501);
        step(3);
        check({7'h00, empty, acc}, 16'h0001);
        step(3);
        check(pc, 16'h0200);
        step(3);
        check({7'h00, empty, acc}, 16'h0100);
        step(3);
        check(pc, 16'h0203);
        step(6);
        check(pc, 16'h0105);
        check({8'h00, sp}, 16'h00FF);
        step(4);
        check({8'h00, ccbs_mem_model_i.mem[16'h0002]}, 16'h0000);
        check({14'h0000, msb, empty}, 16'h0001);
        $display("test_call_return finished");
    endtask : test_call_return
    task automatic test_bit_loop();
        int branch_on_cleared_bit_cyc, ld_cyc;
        step(2);
        check({14'h0000, msb, empty}, 16'h0002);
        step(3);
        check(pc, 16'h010B);
        step(5);
        branch_on_cleared_bit_cyc = cyc;
        check(pc, 16'h010B);
        ccbs_mem_model_i.mem[16'h0001] = 8'h80;
        step(5);
        check(pc, 16'h010E);
        ccbs_mem_model_i.mem[16'h0001] = 8'h00;
        step(3);
        ld_cyc = cyc;
        check({14'h0000, msb, empty}, 16'h0001);
        step(3);
        check(16'(ld_cyc + cyc), 16'(branch_on_cleared_bit_cyc + 1));
        check(pc, 16'h010E);
        ccbs_mem_model_i.mem[16'h0001] = 8'h80;
        step(3);
        step(3);
        check(pc, 16'h0112);
        $display("test_bit_loop finished");
    endtask : test_bit_loop
    // Relative call into a bare return, then a set-bit branch on the same direct byte.
    task automatic test_rel_call();
        step(6);
        check(pc, 16'h0120);
        check({ccbs_mem_model_i.mem[16'h00FF], ccbs_mem_model_i.mem[16'h00FE]}, 16'h1401);
        step(6);
        check(pc, 16'h0114);
        check({8'h00, sp}, 16'h00FF);
        step(5);
        check(pc, 16'h0119);
        $display("test_rel_call finished");
    endtask : test_rel_call
    initial begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        arst_n_in = 1'b0;
        for (int i = 0; i < 23; i++) begin
            ccbs_mem_model_i.mem[16'h0100 + i] = prog[i];
        end
        ccbs_mem_model_i.mem[16'h0200] = 8'h4A;
        ccbs_mem_model_i.mem[16'h0201] = 8'h26;
        ccbs_mem_model_i.mem[16'h0202] = 8'hFD;
        ccbs_mem_model_i.mem[16'h0203] = 8'h81;
        ccbs_mem_model_i.mem[16'h0120] = 8'h81;
        ccbs_mem_model_i.mem[16'h0001] = 8'h00;
        repeat (12) @(posedge sys_clk_in);
        #1;
        arst_n_in = 1'b1;
        test_call_return();
        test_bit_loop();
        test_rel_call();
        report_and_stop();
    end
endmodule : cpu_call_branch_sequencer_tb
